// >>> logic/idec_pkg.sv
package idec_pkg;

  // Instruction word and field geometry.
  localparam int IW       = 14;
  localparam int DW       = 8;
  localparam int FAW      = 7;
  localparam int BAW      = 6;
  localparam int PCW      = 12;
  localparam int D_POS    = 7;
  localparam int BIT_LSB  = 6;
  localparam int CLS_LSB  = 12;
  localparam int OP6_LSB  = 8;
  localparam int OP5_LSB  = 9;

  // Instruction classes by top two bits.
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT  = 2'h1;
  localparam logic [1:0] CLS_CALL = 2'h2;
  localparam logic [1:0] CLS_GOTO = 2'h3;

  // Six-bit opcode prefixes.
  localparam logic [5:0] OP_ADDF = 6'h07;
  localparam logic [5:0] OP_ANDF = 6'h05;
  localparam logic [5:0] OP_ADDK = 6'h1C;
  localparam logic [5:0] OP_ANDK = 6'h1B;
  localparam logic [5:0] OP_RETK = 6'h18;
  localparam logic [5:0] OP_MOVK = 6'h19;

  // Five-bit prefixes of bit-oriented operations.
  localparam logic [4:0] OP_BCLR = 5'h08;
  localparam logic [4:0] OP_BSET = 5'h09;
  localparam logic [4:0] OP_BTLO = 5'h0A;
  localparam logic [4:0] OP_BTHI = 5'h0B;

  // Whole-word encodings.
  localparam logic [13:0] W_SLEEP = 14'h1E03;
  localparam logic [13:0] W_WDCLR = 14'h1E04;
  localparam logic [13:0] W_TABL  = 14'h0050;
  localparam logic [13:0] W_TABH  = 14'h0058;
  localparam logic [13:0] W_RET   = 14'h0040;

  // Upper table data bits beyond the low byte.
  localparam int TAB_HI_W = IW - DW;

  typedef enum logic [2:0] {
    ST_EXEC, ST_TABLE, ST_FLUSH, ST_SLEEP
  } exec_e;

endpackage

// >>> logic/mcu_instruction_decoder.sv
`timescale 1ns/1ps
module mcu_instruction_decoder #(
  parameter int STACK_DEPTH = 6
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       wake_req,
  input  wire logic [idec_pkg::IW-1:0]    instr_word,
  input  wire logic [idec_pkg::DW-1:0]    file_rdata,
  input  wire logic [idec_pkg::IW-1:0]    table_rdata,
  input  wire logic [idec_pkg::PCW-1:0]   table_ptr,
  output logic      [idec_pkg::PCW-1:0]   prog_addr_ff,
  output logic      [idec_pkg::FAW-1:0]   file_addr_ff,
  output logic                            file_plane_r_ff,
  output logic                            file_we_ff,
  output logic      [idec_pkg::DW-1:0]    file_wdata_ff,
  output logic      [idec_pkg::DW-1:0]    acc_ff,
  output logic                            carry_ff,
  output logic                            nib_carry_ff,
  output logic                            zero_ff,
  output logic                            watchdog_expiry_flag_ff,
  output logic                            sleep_entry_flag_ff,
  output logic                            wdt_clear_ff,
  output logic                            sleeping_ff,
  output logic                            phase_ff
);

  localparam int SPW = $clog2(STACK_DEPTH + 1);
  // A met skip steps the fetch address past the word it discards.
  localparam logic [idec_pkg::PCW-1:0] SKIP_STEP = 12'h002;

  idec_pkg::exec_e state_ff;
  idec_pkg::exec_e nxt_state;

  logic [idec_pkg::PCW-1:0] stack_ff [STACK_DEPTH];
  logic [SPW-1:0]           sp_ff;
  logic [idec_pkg::PCW-1:0] pc_ff;
  logic [idec_pkg::DW-1:0]  pend_acc_ff;

  // Synchroniser for the asynchronous wake request.
  logic [2:0] wake_sync_ff;

  // Fields of the word currently executing.
  logic [1:0]                cls;
  logic [5:0]                op6;
  logic [4:0]                op5;
  logic                      dst_file;
  logic [idec_pkg::FAW-1:0]  faddr;
  logic [idec_pkg::BAW-1:0]  baddr;
  logic [2:0]                bsel;
  logic [idec_pkg::DW-1:0]   kimm;
  logic [idec_pkg::PCW-1:0]  ktgt;

  assign cls      = instr_word[idec_pkg::IW-1 -: 2];
  assign op6      = instr_word[idec_pkg::IW-1 -: 6];
  assign op5      = instr_word[idec_pkg::IW-1 -: 5];
  assign dst_file = instr_word[idec_pkg::D_POS];
  assign faddr    = instr_word[idec_pkg::FAW-1:0];
  assign baddr    = instr_word[idec_pkg::BAW-1:0];
  assign bsel     = instr_word[idec_pkg::BIT_LSB +: 3];
  assign kimm     = instr_word[idec_pkg::DW-1:0];
  assign ktgt     = instr_word[idec_pkg::PCW-1:0];

  // Nine-bit add gives carry; nibble add gives decimal carry.
  function automatic logic [idec_pkg::DW+1:0] add8(
    input logic [idec_pkg::DW-1:0] a,
    input logic [idec_pkg::DW-1:0] b
  );
    logic [idec_pkg::DW:0] s;
    logic [4:0]            n;
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {n[4], s};
  endfunction

  // Combinational execute view of the present word.
  logic [idec_pkg::DW+1:0] sum;
  logic [idec_pkg::DW-1:0] andv;
  logic [idec_pkg::DW-1:0] bitmask;
  logic                    exec_now;
  logic                    is_addf, is_andf, is_addk, is_andk, is_movk;
  logic                    is_bclr, is_bset, is_skip_lo, is_skip_hi;
  logic                    is_retk, is_ret, is_call, is_goto;
  logic                    is_sleep, is_wdclr, is_tabl, is_tabh;
  logic                    skip_met;

  assign exec_now   = (state_ff == idec_pkg::ST_EXEC) && phase_ff;
  assign is_addf    = (op6 == idec_pkg::OP_ADDF);
  assign is_andf    = (op6 == idec_pkg::OP_ANDF);
  assign is_addk    = (op6 == idec_pkg::OP_ADDK);
  assign is_andk    = (op6 == idec_pkg::OP_ANDK);
  assign is_movk    = (op6 == idec_pkg::OP_MOVK);
  assign is_retk    = (op6 == idec_pkg::OP_RETK);
  assign is_bclr    = (op5 == idec_pkg::OP_BCLR);
  assign is_bset    = (op5 == idec_pkg::OP_BSET);
  assign is_skip_lo = (op5 == idec_pkg::OP_BTLO);
  assign is_skip_hi = (op5 == idec_pkg::OP_BTHI);
  assign is_call    = (cls == idec_pkg::CLS_CALL);
  assign is_goto    = (cls == idec_pkg::CLS_GOTO);
  assign is_ret     = (instr_word == idec_pkg::W_RET);
  assign is_sleep   = (instr_word == idec_pkg::W_SLEEP);
  assign is_wdclr   = (instr_word == idec_pkg::W_WDCLR);
  assign is_tabl    = (instr_word == idec_pkg::W_TABL);
  assign is_tabh    = (instr_word == idec_pkg::W_TABH);
  assign sum        = add8(acc_ff, is_addk ? kimm : file_rdata);
  assign andv       = acc_ff & (is_andk ? kimm : file_rdata);
  assign bitmask    = idec_pkg::DW'(1) << bsel;
  assign skip_met   = (is_skip_lo && !file_rdata[bsel]) ||
                      (is_skip_hi && file_rdata[bsel]);

  // Operand address is presented as soon as the word is seen.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      file_addr_ff    <= '0;
      file_plane_r_ff <= 1'b0;
    end else if (cls == idec_pkg::CLS_BIT) begin
      file_addr_ff    <= {1'b0, baddr};
      file_plane_r_ff <= 1'b0;
    end else begin
      file_addr_ff    <= faddr;
      file_plane_r_ff <= 1'b0;
    end
  end

  // Two system clocks make one instruction cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sleeping_ff) begin
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
    end
  end

  // Wake request crosses in; the second and third stages must agree.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_sync_ff <= '0;
    end else begin
      wake_sync_ff <= {wake_sync_ff[1:0], wake_req};
    end
  end

  // Sequencer: extra instruction cycles for tables, branches, skips.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      idec_pkg::ST_EXEC: begin
        if (exec_now) begin
          if (is_tabl || is_tabh) begin
            nxt_state = idec_pkg::ST_TABLE;
          end else if (is_call || is_goto || is_ret || is_retk ||
                       skip_met) begin
            nxt_state = idec_pkg::ST_FLUSH;
          end else if (is_sleep) begin
            nxt_state = idec_pkg::ST_SLEEP;
          end
        end
      end
      idec_pkg::ST_TABLE,
      idec_pkg::ST_FLUSH: begin
        if (phase_ff) begin
          nxt_state = idec_pkg::ST_EXEC;
        end
      end
      idec_pkg::ST_SLEEP: begin
        if (wake_sync_ff[1] && wake_sync_ff[2]) begin
          nxt_state = idec_pkg::ST_EXEC;
        end
      end
      default: nxt_state = idec_pkg::ST_EXEC;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff    <= idec_pkg::ST_EXEC;
      sleeping_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      sleeping_ff <= (nxt_state == idec_pkg::ST_SLEEP);
    end
  end

  // Program counter and stack; a skip or branch flushes the fetched word.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pc_ff        <= '0;
      prog_addr_ff <= '0;
      sp_ff        <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_ff[i] <= '0;
      end
    end else if (exec_now) begin
      if (is_call) begin
        stack_ff[sp_ff] <= pc_ff + 1'b1;
        if (sp_ff < SPW'(STACK_DEPTH - 1)) begin
          sp_ff <= sp_ff + 1'b1;
        end
        pc_ff        <= ktgt;
        prog_addr_ff <= ktgt;
      end else if (is_goto) begin
        pc_ff        <= ktgt;
        prog_addr_ff <= ktgt;
      end else if (is_ret || is_retk) begin
        pc_ff        <= stack_ff[sp_ff - 1'b1];
        prog_addr_ff <= stack_ff[sp_ff - 1'b1];
        if (sp_ff != '0) begin
          sp_ff <= sp_ff - 1'b1;
        end
      end else if (is_tabl || is_tabh) begin
        prog_addr_ff <= table_ptr;
      end else if (skip_met) begin
        // Stepping at execute keeps the flush cycle a plain wait, so a
        // branch target is never stepped over by mistake.
        pc_ff        <= pc_ff + SKIP_STEP;
        prog_addr_ff <= pc_ff + SKIP_STEP;
      end else begin
        pc_ff        <= pc_ff + 1'b1;
        prog_addr_ff <= pc_ff + 1'b1;
      end
    end else if (state_ff == idec_pkg::ST_TABLE && phase_ff) begin
      pc_ff        <= pc_ff + 1'b1;
      prog_addr_ff <= pc_ff + 1'b1;
    end
  end

  // Accumulator, flags and file write-back.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_ff        <= '0;
      pend_acc_ff   <= '0;
      carry_ff      <= 1'b0;
      nib_carry_ff  <= 1'b0;
      zero_ff       <= 1'b0;
      file_we_ff    <= 1'b0;
      file_wdata_ff <= '0;
    end else begin
      file_we_ff <= 1'b0;
      if (exec_now) begin
        if (is_addk || is_addf) begin
          carry_ff     <= sum[idec_pkg::DW];
          nib_carry_ff <= sum[idec_pkg::DW+1];
          zero_ff      <= (sum[idec_pkg::DW-1:0] == '0);
          if (is_addf && dst_file) begin
            file_we_ff    <= 1'b1;
            file_wdata_ff <= sum[idec_pkg::DW-1:0];
          end else begin
            acc_ff <= sum[idec_pkg::DW-1:0];
          end
        end else if (is_andk || is_andf) begin
          zero_ff <= (andv == '0);
          if (is_andf && dst_file) begin
            file_we_ff    <= 1'b1;
            file_wdata_ff <= andv;
          end else begin
            acc_ff <= andv;
          end
        end else if (is_bclr) begin
          file_we_ff    <= 1'b1;
          file_wdata_ff <= file_rdata & ~bitmask;
        end else if (is_bset) begin
          file_we_ff    <= 1'b1;
          file_wdata_ff <= file_rdata | bitmask;
        end else if (is_movk) begin
          acc_ff <= kimm;
        end else if (is_retk) begin
          acc_ff <= kimm;
        end else if (is_tabl) begin
          pend_acc_ff <= idec_pkg::DW'(0);
        end else if (is_tabh) begin
          pend_acc_ff <= 8'h01;
        end
        // Anything else leaves all state alone.
      end else if (state_ff == idec_pkg::ST_TABLE && phase_ff) begin
        // The table word arrives one instruction cycle later.
        if (pend_acc_ff[0]) begin
          acc_ff <= idec_pkg::DW'(
                    table_rdata[idec_pkg::IW-1:idec_pkg::DW]);
        end else begin
          acc_ff <= table_rdata[idec_pkg::DW-1:0];
        end
      end
    end
  end

  // Timeout and power-down flags, plus the watchdog restart pulse.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      watchdog_expiry_flag_ff <= 1'b1;
      sleep_entry_flag_ff     <= 1'b1;
      wdt_clear_ff            <= 1'b0;
    end else begin
      // Only the restart instruction clears the counters.
      wdt_clear_ff <= exec_now && is_wdclr;
      if (exec_now && is_wdclr) begin
        watchdog_expiry_flag_ff <= 1'b1;
        sleep_entry_flag_ff     <= 1'b1;
      end else if (exec_now && is_sleep) begin
        watchdog_expiry_flag_ff <= 1'b1;
        sleep_entry_flag_ff     <= 1'b0;
      end
    end
  end

endmodule

// >>> tb/mcu_instruction_decoder_chk_sva.sv
`timescale 1ns/1ps
module mcu_instruction_decoder_chk #(
  parameter int STACK_DEPTH = 6
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [13:0] instr_word,
  input wire logic [7:0]  file_rdata,
  input wire logic        file_we_ff,
  input wire logic [7:0]  file_wdata_ff,
  input wire logic [7:0]  acc_ff,
  input wire logic        carry_ff,
  input wire logic        nib_carry_ff,
  input wire logic        zero_ff,
  input wire logic        watchdog_expiry_flag_ff,
  input wire logic        sleep_entry_flag_ff,
  input wire logic        wdt_clear_ff,
  input wire logic        sleeping_ff,
  input wire logic        phase_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A discarded word shows no change, so each check also allows stability.
  sequence run_op(op);
    phase_ff && !sleeping_ff && instr_word[13:8] == op;
  endsequence

  a_add_sum: assert property (run_op(idec_pkg::OP_ADDK) |=>
    $stable(acc_ff) || {carry_ff, acc_ff} ==
    {1'b0, $past(acc_ff)} + $past(instr_word[7:0]))
    else $error("immediate add gave a wrong sum");
  a_and_zero: assert property (run_op(idec_pkg::OP_ANDK) |=>
    $stable(acc_ff) || (acc_ff == ($past(acc_ff) & $past(instr_word[7:0]))
    && zero_ff == (acc_ff == 8'h00)))
    else $error("immediate and gave a wrong result");
  a_bit_flags: assert property (phase_ff && instr_word[13:10] == 4'h4 |=>
    $stable({carry_ff, nib_carry_ff, zero_ff}))
    else $error("bit operation moved a flag");
  a_clear_data: assert property (phase_ff && !sleeping_ff &&
    instr_word[13:9] == idec_pkg::OP_BCLR |=> !file_we_ff || file_wdata_ff
    == ($past(file_rdata) & ~(8'h01 << $past(instr_word[8:6]))))
    else $error("bit clear wrote a wrong byte");
  a_noop_quiet: assert property (run_op(6'h0D) |=>
    !file_we_ff && $stable(acc_ff))
    else $error("unlisted word changed state");
  a_acc_phase: assert property (!phase_ff |=>
    $stable(acc_ff) && $stable(zero_ff))
    else $error("accumulator changed off the execute edge");
  a_we_pulse: assert property (file_we_ff |->
    !phase_ff ##1 !file_we_ff)
    else $error("file write strobe misplaced");
  a_wdt_flags: assert property (wdt_clear_ff |->
    watchdog_expiry_flag_ff && sleep_entry_flag_ff ##1 !wdt_clear_ff)
    else $error("watchdog restart flags or pulse wrong");
endmodule

bind mcu_instruction_decoder mcu_instruction_decoder_chk #(
  .STACK_DEPTH(STACK_DEPTH)
) chk_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .instr_word(instr_word),
  .file_rdata(file_rdata), .file_we_ff(file_we_ff),
  .file_wdata_ff(file_wdata_ff), .acc_ff(acc_ff), .carry_ff(carry_ff),
  .nib_carry_ff(nib_carry_ff), .zero_ff(zero_ff),
  .watchdog_expiry_flag_ff(watchdog_expiry_flag_ff),
  .sleep_entry_flag_ff(sleep_entry_flag_ff), .wdt_clear_ff(wdt_clear_ff),
  .sleeping_ff(sleeping_ff), .phase_ff(phase_ff)
);

// >>> tb/mcu_mem_model.sv
`timescale 1ns/1ps
module mcu_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [11:0] prog_addr_ff,
  input  wire logic [6:0]  file_addr_ff,
  input  wire logic        file_we_ff,
  input  wire logic [7:0]  file_wdata_ff,
  output logic      [13:0] instr_word,
  output logic      [13:0] table_rdata,
  output logic      [7:0]  file_rdata
);
  logic [13:0] rom  [64];
  logic [7:0]  regs [128];

  // Small program store; upper address bits alias, so keep code low.
  assign instr_word  = rom[prog_addr_ff[5:0]];
  assign table_rdata = rom[prog_addr_ff[5:0]];
  assign file_rdata  = regs[file_addr_ff];

  // The bench also preloads regs, so this is not a sole-driver process.
  always @(posedge sys_clk) begin
    if (file_we_ff) begin
      regs[file_addr_ff] <= file_wdata_ff;
    end
  end
endmodule

// >>> tb/mcu_instruction_decoder_test.sv
`timescale 1ns/1ps
module mcu_instruction_decoder_test;
  logic        sys_clk;
  logic        rst_n;
  logic        wake_req;
  logic [11:0] table_ptr;
  logic [13:0] instr_word;
  logic [13:0] table_rdata;
  logic [7:0]  file_rdata;
  logic [11:0] prog_addr_ff;
  logic [6:0]  file_addr_ff;
  logic        file_plane_r_ff;
  logic        file_we_ff;
  logic [7:0]  file_wdata_ff;
  logic [7:0]  acc_ff;
  logic        carry_ff;
  logic        nib_carry_ff;
  logic        zero_ff;
  logic        watchdog_expiry_flag_ff;
  logic        sleep_entry_flag_ff;
  logic        wdt_clear_ff;
  logic        sleeping_ff;
  logic        phase_ff;
  int          n_mismatch;
  int          total_checks;
  int          n_wdt;

  mcu_instruction_decoder mcu_instruction_decoder_inst (
    .sys_clk                 (sys_clk),
    .rst_n                   (rst_n),
    .wake_req                (wake_req),
    .instr_word              (instr_word),
    .file_rdata              (file_rdata),
    .table_rdata             (table_rdata),
    .table_ptr               (table_ptr),
    .prog_addr_ff            (prog_addr_ff),
    .file_addr_ff            (file_addr_ff),
    .file_plane_r_ff         (file_plane_r_ff),
    .file_we_ff              (file_we_ff),
    .file_wdata_ff           (file_wdata_ff),
    .acc_ff                  (acc_ff),
    .carry_ff                (carry_ff),
    .nib_carry_ff            (nib_carry_ff),
    .zero_ff                 (zero_ff),
    .watchdog_expiry_flag_ff (watchdog_expiry_flag_ff),
    .sleep_entry_flag_ff     (sleep_entry_flag_ff),
    .wdt_clear_ff            (wdt_clear_ff),
    .sleeping_ff             (sleeping_ff),
    .phase_ff                (phase_ff)
  );
  mcu_mem_model mcu_mem_model_inst (
    .sys_clk       (sys_clk),
    .prog_addr_ff  (prog_addr_ff),
    .file_addr_ff  (file_addr_ff),
    .file_we_ff    (file_we_ff),
    .file_wdata_ff (file_wdata_ff),
    .instr_word    (instr_word),
    .table_rdata   (table_rdata),
    .file_rdata    (file_rdata)
  );

  // Free-running 200 MHz core clock.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Counts watchdog restart pulses seen during a run.
  always @(posedge sys_clk) begin
    if (wdt_clear_ff === 1'b1) n_wdt++;
  end

  function automatic logic [7:0] fl();
    return {5'h0, carry_ff, nib_carry_ff, zero_ff};
  endfunction

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Unused words jump to themselves, so a run parks instead of wandering.
  task automatic load(input logic [13:0] p[$]);
    @(negedge sys_clk);
    rst_n = 1'b0;
    for (int i = 0; i < 64; i++) mcu_mem_model_inst.rom[i] = 14'h3000 | 14'(i);
    foreach (p[i]) mcu_mem_model_inst.rom[i] = p[i];
    n_wdt = 0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
  endtask

  task automatic park(input logic [11:0] a);
    int n;
    n = 0;
    while (prog_addr_ff !== a && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    check("park address", 8'(a), 8'(prog_addr_ff));
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic t_add;
    load('{14'h1CF0, 14'h1C15});
    park(12'h002);
    check("sum", 8'h05, acc_ff);
    check("sum flags", 8'h04, fl());
    load('{14'h1CF0, 14'h1C15, 14'h1CFB});
    park(12'h003);
    check("wrap", 8'h00, acc_ff);
    check("wrap flags", 8'h07, fl());
    $display("test add done");
  endtask

  task automatic t_and;
    load('{14'h1CA3, 14'h1B5F});
    park(12'h002);
    check("and", 8'h03, acc_ff);
    check("and flags", 8'h00, fl());
    load('{14'h1CA3, 14'h1B5F, 14'h1B00});
    park(12'h003);
    check("and zero", 8'h01, fl());
    $display("test and done");
  endtask

  task automatic t_file;
    load('{14'h1C17, 14'h0721, 14'h05A1});
    mcu_mem_model_inst.regs[33] = 8'hC2;
    park(12'h003);
    check("file add", 8'hD9, acc_ff);
    check("file and", 8'hC0, mcu_mem_model_inst.regs[33]);
    check("file flags", 8'h00, fl());
    check("file plane", 8'h00, 8'(file_plane_r_ff));
    $display("test file done");
  endtask

  task automatic t_bit;
    load('{14'h1C00, 14'h11C5, 14'h13C6});
    mcu_mem_model_inst.regs[5] = 8'hC7;
    mcu_mem_model_inst.regs[6] = 8'h0A;
    park(12'h003);
    check("bit clear", 8'h47, mcu_mem_model_inst.regs[5]);
    check("bit set", 8'h8A, mcu_mem_model_inst.regs[6]);
    check("bit flags", 8'h01, fl());
    $display("test bit done");
  endtask

  task automatic t_skip;
    load('{14'h1405, 14'h1C01, 14'h1C02});
    mcu_mem_model_inst.regs[5] = 8'hFE;
    park(12'h003);
    check("skip", 8'h02, acc_ff);
    load('{14'h1445, 14'h1C01, 14'h1C02});
    mcu_mem_model_inst.regs[5] = 8'hFE;
    park(12'h003);
    check("no skip", 8'h03, acc_ff);
    $display("test skip done");
  endtask

  task automatic t_table;
    load('{14'h0050});
    mcu_mem_model_inst.rom[32] = 14'h2A5C;
    park(12'h001);
    check("table low", 8'h5C, acc_ff);
    load('{14'h0058});
    mcu_mem_model_inst.rom[32] = 14'h2A5C;
    park(12'h001);
    check("table high", 8'h2A, acc_ff);
    load('{14'h2010, 14'h1C01, 14'h0DA1, 14'h1C05});
    mcu_mem_model_inst.rom[16] = 14'h1840;
    mcu_mem_model_inst.regs[33] = 8'hC2;
    park(12'h004);
    check("call return", 8'h46, acc_ff);
    check("unlisted", 8'hC2, mcu_mem_model_inst.regs[33]);
    $display("test control done");
  endtask

  task automatic t_sleep;
    int n;
    load('{14'h1E03, 14'h1C07, 14'h1E04});
    check("reset flags", 8'h03,
          {6'h0, watchdog_expiry_flag_ff, sleep_entry_flag_ff});
    for (n = 0; n < 100 && sleeping_ff !== 1'b1; n++) @(negedge sys_clk);
    repeat (10) @(negedge sys_clk);
    check("asleep", 8'h01, 8'(sleeping_ff));
    check("sleep flags", 8'h02,
          {6'h0, watchdog_expiry_flag_ff, sleep_entry_flag_ff});
    check("halted", 8'h00, acc_ff);
    wake_req = 1'b1;
    for (n = 0; n < 100 && sleeping_ff !== 1'b0; n++) @(negedge sys_clk);
    wake_req = 1'b0;
    park(12'h003);
    check("woken", 8'h07, acc_ff);
    check("restart flags", 8'h03,
          {6'h0, watchdog_expiry_flag_ff, sleep_entry_flag_ff});
    check("restart pulses", 8'h01, 8'(n_wdt));
    $display("test sleep done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // About 200 cycles are expected; the limit leaves ample margin.
  initial begin
    #80us;
    n_mismatch++;
    $display("mismatch run time expected done seen hang");
    finish_test();
  end

  // Main sequence: preload, hold reset, then each scenario in turn.
  initial begin
    rst_n = 1'b0;
    wake_req = 1'b0;
    table_ptr = 12'h020;
    n_mismatch = 0;
    total_checks = 0;
    n_wdt = 0;
    foreach (mcu_mem_model_inst.rom[i]) mcu_mem_model_inst.rom[i] = 14'h0;
    foreach (mcu_mem_model_inst.regs[i]) mcu_mem_model_inst.regs[i] = 8'h0;
    repeat (12) @(negedge sys_clk);
    t_add();
    t_and();
    t_file();
    t_bit();
    t_skip();
    t_table();
    t_sleep();
    finish_test();
  end
endmodule
